// ==== err_loc_pkg.sv ====
// Package: register map, field layout and encodings of the error location counter
package err_loc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PATLEN_OFS = 8'h04;
  localparam logic [7:0] START_OFS = 8'h08;
  localparam logic [7:0] LENGTH_OFS = 8'h0C;
  localparam logic [7:0] BITADDR_OFS = 8'h10;
  localparam logic [7:0] CAPCMD_OFS = 8'h14;
  localparam logic [7:0] CAPSTATE_OFS = 8'h18;
  localparam logic [7:0] ERRCNT_OFS = 8'h1C;
  localparam logic [7:0] CAPCNT_OFS = 8'h20;
  localparam logic [7:0] INCLIST_OFS = 8'h24;
  // ----------------------------------------
  // Control and capture command register fields
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MASK_BIT = 2;
  localparam int INCR_BIT = 3;
  localparam int LOC_LSB = 4;
  localparam int USER_BIT = 6;
  localparam int ONCE_BIT = 0;
  localparam int OFF_BIT = 1;
  // Allowed sync-loss increments, bit n set means n allowed
  localparam logic [31:0] INC_LIST = 32'h0000_0003;
  localparam logic INCR_RST = 1'b1;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    BIT_COMPARE = 2'h0,
    SYMBOL_COMPARE = 2'h1,
    BIT_COMPARE_SKIP_PCIE3 = 2'h2,
    BIT_COMPARE_SKIP_USB31 = 2'h3
  } er_mode_type;
  typedef enum logic [1:0] {
    WHOLE_PATTERN_MODE = 2'h0,
    RANGE_MODE = 2'h1,
    SINGLE_BIT_MODE = 2'h2
  } loc_mode_type;
  typedef enum logic [5:0] {
    CAPTURE_STATE_IDLE = 6'h01,
    CAPTURE_STATE_RUNNING = 6'h02,
    CAPTURE_STATE_HIT = 6'h04,
    CAPTURE_STATE_SUCCESS = 6'h08,
    CAPTURE_STATE_FAILED = 6'h10,
    CAPTURE_STATE_ABORTED = 6'h20
  } cap_state_type;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : err_loc_pkg

// ==== error_location_counter.sv ====
// Error qualification, location filtering and one-shot error capture
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module error_location_counter
  import err_loc_pkg::*;
#(
  parameter int AW = 16,
  parameter logic [15:0] PATLEN_RST = 16'h0400
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Comparator stream, same clock
  input wire logic cmp_valid_in,
  input wire logic bit_err_in,
  input wire logic sym_err_in,
  input wire logic skip_in,
  input wire logic resync_in,
  input wire logic sync_loss_in
);
  // ----------------------------------------
  // Configuration and state registers
  // ----------------------------------------
  er_mode_type er_mode_ff; // Error ratio mode
  logic mask_resync_errors_ff; // Mask resync errors
  logic incr_ff; // Sync loss increment
  loc_mode_type loc_mode_ff; // Location mode
  logic user_defined_pattern_ff; // User pattern selected
  logic [AW-1:0] patlen_ff; // Pattern length
  logic [AW-1:0] range_start_address_ff;
  logic [AW-1:0] range_length_ff;
  logic [AW-1:0] single_bit_address_ff;
  logic [AW-1:0] addr_ff; // Pattern bit address
  logic [31:0] err_cnt_ff; // Running error counter
  cap_state_type cap_state_ff; // Capture state
  logic cmd_status_ff; // Capture command status
  logic captured_ff; // Error captured since start
  logic [AW-1:0] cap_addr_ff; // Captured bit position
  logic [AW-1:0] eval_cnt_ff; // Bits evaluated after hit
  logic [31:0] run_errs_ff; // Errors during evaluation
  logic [31:0] captured_error_count_ff;
  // Bus phase registers
  logic wr_pend_ff;
  logic [7:0] wr_ofs_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic rd_acc;
  logic [31:0] rd_val;
  logic wr_ctrl;
  logic wr_start;
  logic wr_len;
  logic cmd_once;
  logic cmd_off;
  logic cap_allowed;
  logic cap_busy; // Capture running or evaluating
  logic [AW-1:0] lim; // Pattern length minus one

  // Valid transfer in address phase
  assign acc = hsel_in & hready_in & (htrans_in == HTRANS_NONSEQ);
  assign rd_acc = acc & ~hwrite_in;
  assign lim = patlen_ff - AW'(1);
  assign wr_ctrl = wr_pend_ff & (wr_ofs_ff == CTRL_OFS);
  assign wr_start = wr_pend_ff & (wr_ofs_ff == START_OFS);
  assign wr_len = wr_pend_ff & (wr_ofs_ff == LENGTH_OFS);
  assign cmd_once = wr_pend_ff & (wr_ofs_ff == CAPCMD_OFS) & hwdata_in[ONCE_BIT];
  assign cmd_off = wr_pend_ff & (wr_ofs_ff == CAPCMD_OFS) & hwdata_in[OFF_BIT];
  // Capture is unavailable in symbol and PCIe3 skip modes
  assign cap_allowed = (er_mode_ff != SYMBOL_COMPARE) &&
                       (er_mode_ff != BIT_COMPARE_SKIP_PCIE3);
  assign cap_busy = (cap_state_ff == CAPTURE_STATE_RUNNING) ||
                    (cap_state_ff == CAPTURE_STATE_HIT);

  // Latch write address phase, zero wait state slave
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= acc & hwrite_in;
      wr_ofs_ff <= haddr_in[7:0];
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr_in[7:0] == CTRL_OFS) begin
      rd_val[MODE_LSB +: 2] = er_mode_ff;
      rd_val[MASK_BIT] = mask_resync_errors_ff;
      rd_val[INCR_BIT] = incr_ff;
      rd_val[LOC_LSB +: 2] = loc_mode_ff;
      rd_val[USER_BIT] = user_defined_pattern_ff;
    end else if (haddr_in[7:0] == PATLEN_OFS) begin
      rd_val[AW-1:0] = patlen_ff;
    end else if (haddr_in[7:0] == START_OFS) begin
      rd_val[AW-1:0] = range_start_address_ff;
    end else if (haddr_in[7:0] == LENGTH_OFS) begin
      rd_val[AW-1:0] = range_length_ff;
    end else if (haddr_in[7:0] == BITADDR_OFS) begin
      rd_val[AW-1:0] = captured_ff ? cap_addr_ff : single_bit_address_ff;
    end else if (haddr_in[7:0] == CAPCMD_OFS) begin
      rd_val[0] = cmd_status_ff;
    end else if (haddr_in[7:0] == CAPSTATE_OFS) begin
      rd_val[5:0] = cap_state_ff;
    end else if (haddr_in[7:0] == ERRCNT_OFS) begin
      rd_val = err_cnt_ff;
    end else if (haddr_in[7:0] == CAPCNT_OFS) begin
      rd_val = captured_error_count_ff;
    end else if (haddr_in[7:0] == INCLIST_OFS) begin
      rd_val = INC_LIST;
    end
  end

  // Read data registered for the data phase
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_acc) begin
      hrdata_ff <= rd_val;
    end
  end

  // ----------------------------------------
  // Configuration writes
  // ----------------------------------------
  // Control fields, reset to whole pattern and increment one
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      er_mode_ff <= BIT_COMPARE;
      mask_resync_errors_ff <= 1'b0;
      incr_ff <= INCR_RST;
      loc_mode_ff <= WHOLE_PATTERN_MODE;
      user_defined_pattern_ff <= 1'b0;
    end else if (wr_ctrl) begin
      er_mode_ff <= er_mode_type'(hwdata_in[MODE_LSB +: 2]);
      mask_resync_errors_ff <= hwdata_in[MASK_BIT];
      incr_ff <= hwdata_in[INCR_BIT];
      user_defined_pattern_ff <= hwdata_in[USER_BIT];
      // Unused code falls back to whole pattern
      if (hwdata_in[LOC_LSB +: 2] == RANGE_MODE) begin
        loc_mode_ff <= RANGE_MODE;
      end else if (hwdata_in[LOC_LSB +: 2] == SINGLE_BIT_MODE) begin
        loc_mode_ff <= SINGLE_BIT_MODE;
      end else begin
        loc_mode_ff <= WHOLE_PATTERN_MODE;
      end
    end
  end

  // Pattern length and single bit address
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      patlen_ff <= AW'(PATLEN_RST);
      single_bit_address_ff <= '0;
    end else if (wr_pend_ff) begin
      if (wr_ofs_ff == PATLEN_OFS) begin
        patlen_ff <= (hwdata_in[AW-1:0] < AW'(2)) ? AW'(2) : hwdata_in[AW-1:0];
      end else if (wr_ofs_ff == BITADDR_OFS) begin
        single_bit_address_ff <= hwdata_in[AW-1:0];
      end
    end
  end

  // Range start and length, silently clamped
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      range_start_address_ff <= '0;
      range_length_ff <= AW'(1);
    end else if (wr_start) begin
      if (hwdata_in >= 32'(patlen_ff)) begin
        range_start_address_ff <= lim;
      end else begin
        range_start_address_ff <= hwdata_in[AW-1:0];
      end
    end else if (wr_len) begin
      if (hwdata_in == 32'h0000_0000) begin
        range_length_ff <= AW'(1);
      end else if (hwdata_in > 32'(lim)) begin
        range_length_ff <= lim;
      end else begin
        range_length_ff <= hwdata_in[AW-1:0];
      end
    end
  end

  // ----------------------------------------
  // Error qualification
  // ----------------------------------------
  logic [AW-1:0] offset; // Distance from range start
  logic in_loc;
  logic unit_err;
  logic skipped;
  logic count_hit;
  logic add_loss;
  // Wrapped distance from start address
  always_comb begin
    if (addr_ff >= range_start_address_ff) begin
      offset = addr_ff - range_start_address_ff;
    end else begin
      offset = addr_ff + patlen_ff - range_start_address_ff;
    end
  end

  // Location filter acts only for user patterns
  always_comb begin
    in_loc = 1'b1;
    if (user_defined_pattern_ff) begin
      if (loc_mode_ff == SINGLE_BIT_MODE) begin
        in_loc = (addr_ff == single_bit_address_ff);
      end else if (loc_mode_ff == RANGE_MODE) begin
        in_loc = (offset < range_length_ff);
      end
    end
  end

  // Symbol mode counts symbol errors, skip modes drop skip sets
  assign unit_err = (er_mode_ff == SYMBOL_COMPARE) ? sym_err_in : bit_err_in;
  assign skipped = skip_in & ((er_mode_ff == BIT_COMPARE_SKIP_PCIE3) |
                              (er_mode_ff == BIT_COMPARE_SKIP_USB31));
  assign count_hit = cmp_valid_in & unit_err & ~skipped & in_loc &
                     ~(mask_resync_errors_ff & resync_in);
  // Sync loss adds the increment, zero or one
  assign add_loss = sync_loss_in & incr_ff;

  // Pattern bit address counter
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      addr_ff <= '0;
    end else if (cmp_valid_in) begin
      addr_ff <= (addr_ff >= lim) ? '0 : addr_ff + AW'(1);
    end
  end

  // Running error counter
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      err_cnt_ff <= 32'h0000_0000;
    end else begin
      err_cnt_ff <= err_cnt_ff + 32'(count_hit) + 32'(add_loss);
    end
  end

  // ----------------------------------------
  // Capture state machine
  // ----------------------------------------
  // Capture runs; on a hit one pattern is evaluated
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cap_state_ff <= CAPTURE_STATE_IDLE;
      eval_cnt_ff <= '0;
      run_errs_ff <= 32'h0000_0000;
      cap_addr_ff <= '0;
      captured_ff <= 1'b0;
      captured_error_count_ff <= 32'h0000_0000;
    end else if (cmd_off && cap_busy) begin
      cap_state_ff <= CAPTURE_STATE_ABORTED;
    end else if (cmd_once) begin
      captured_ff <= 1'b0;
      cap_state_ff <= cap_allowed ? CAPTURE_STATE_RUNNING
                                  : CAPTURE_STATE_FAILED;
    end else begin
      case (cap_state_ff)
        CAPTURE_STATE_RUNNING: begin
          if (!cap_allowed) begin
            cap_state_ff <= CAPTURE_STATE_FAILED;
          end else if (count_hit) begin
            cap_state_ff <= CAPTURE_STATE_HIT;
            cap_addr_ff <= addr_ff;
            eval_cnt_ff <= AW'(1);
            run_errs_ff <= 32'h0000_0001;
          end
        end
        CAPTURE_STATE_HIT: begin
          if (!cap_allowed) begin
            cap_state_ff <= CAPTURE_STATE_FAILED;
          end else if (eval_cnt_ff >= patlen_ff) begin
            cap_state_ff <= CAPTURE_STATE_SUCCESS;
            captured_ff <= 1'b1;
            captured_error_count_ff <= run_errs_ff;
          end else if (cmp_valid_in) begin
            eval_cnt_ff <= eval_cnt_ff + AW'(1);
            run_errs_ff <= run_errs_ff + 32'(count_hit);
          end
        end
        default: begin
          cap_state_ff <= cap_state_ff;
        end
      endcase
    end
  end

  // Command status: set on start, cleared when the run ends
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmd_status_ff <= 1'b0;
    end else if (cmd_once && !(cmd_off && cap_busy)) begin
      cmd_status_ff <= 1'b1;
    end else if (cmd_off || cap_state_ff == CAPTURE_STATE_SUCCESS ||
                 cap_state_ff == CAPTURE_STATE_FAILED) begin
      cmd_status_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = hreadyout_ff;
  assign hresp_out = hresp_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence start_seq;
    cmd_once && !cmd_off && cap_allowed;
  endsequence
  sequence hit_seq;
    cap_state_ff == CAPTURE_STATE_RUNNING && count_hit && !cmd_off && !cmd_once && cap_allowed;
  endsequence

  addr_wrap_a: assert property (cmp_valid_in && addr_ff == lim |=> addr_ff == '0)
    else $error("bit address did not wrap");
  sync_inc_a: assert property (sync_loss_in && !count_hit |=>
    err_cnt_ff == $past(err_cnt_ff) + 32'($past(incr_ff)))
    else $error("sync loss increment wrong");
  start_clamp_a: assert property (wr_start && hwdata_in >= 32'(patlen_ff) |=>
    range_start_address_ff == $past(lim))
    else $error("start not clamped");
  len_clamp_a: assert property (wr_len && hwdata_in == 32'h0000_0000 |=>
    range_length_ff == AW'(1))
    else $error("zero length not forced to one");
  run_start_a: assert property (start_seq |=>
    cmd_status_ff && cap_state_ff == CAPTURE_STATE_RUNNING && !captured_ff)
    else $error("capture did not start");
  disabled_cap_a: assert property (cmd_once && !cmd_off && !cap_allowed |=>
    cap_state_ff == CAPTURE_STATE_FAILED)
    else $error("capture ran in disabled mode");
  hit_addr_a: assert property (hit_seq |=>
    cap_state_ff == CAPTURE_STATE_HIT && cap_addr_ff == $past(addr_ff))
    else $error("errored bit position not stored");
  abort_none_a: assert property (cmd_off && cap_state_ff == CAPTURE_STATE_HIT |=>
    cap_state_ff == CAPTURE_STATE_ABORTED && $stable(captured_error_count_ff)
    ##1 !cmd_status_ff || cmd_once)
    else $error("aborted capture changed results");
  single_bit_a: assert property (count_hit && user_defined_pattern_ff &&
    loc_mode_ff == SINGLE_BIT_MODE |-> addr_ff == single_bit_address_ff)
    else $error("error counted off the single bit");
  count_only_a: assert property (!$stable(captured_error_count_ff) |->
    cap_state_ff == CAPTURE_STATE_SUCCESS && $past(cap_state_ff) == CAPTURE_STATE_HIT)
    else $error("captured count changed without success");
endmodule : error_location_counter
`default_nettype wire

// ==== error_location_counter_tb_top.sv ====
// Self-checking bench for the error location counter
`timescale 1ns/1ps
`default_nettype none
module error_location_counter_tb_top;
  import err_loc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int PL = 8; // Pattern length after reset
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp;
  logic req = 1'b0;
  logic err = 1'b0;
  logic loss = 1'b0;
  logic skp = 1'b0; // Skip ordered set flag for the next bit
  logic rsy = 1'b0; // Resync flag for the next bit
  logic cmp_valid, bit_err, sym_err, skip, resync, sync_loss;
  int err_count = 0;
  int num_checks = 0;
  int b_addr = 0; // Bench copy of the pattern bit address
  int cnt_exp = 0; // Expected running error count
  int cap_exp = 0; // Expected captured error count
  int hit_addr = 0;
  int hit_left = 0;
  int cap_keep = 0; // Captured count held across an aborted run
  bit armed = 1'b0; // Capture waiting for its first counted error
  int c_incr, c_loc, c_user, c_st, c_ln, c_sb, c_mode, c_mask;
  // ---------------------------------------------------------------
  // Instances and clock
  // ---------------------------------------------------------------
  error_location_counter #(.PATLEN_RST(16'h0008)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .cmp_valid_in(cmp_valid),
    .bit_err_in(bit_err), .sym_err_in(sym_err), .skip_in(skip), .resync_in(resync),
    .sync_loss_in(sync_loss));
  stream_source_model src (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .err_in(err),
    .loss_in(loss), .skip_in(skp), .resync_in(rsy), .cmp_valid_out(cmp_valid),
    .bit_err_out(bit_err), .sym_err_out(sym_err),
    .skip_out(skip), .resync_out(resync), .sync_loss_out(sync_loss));
  always #12.5 clk_in = ~clk_in;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Compare a register value
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t register read %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg
  // Compare an error count
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t error count %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus wait timed out", $time);
      wrap_up();
    end
  endtask : wait_rdy
  // One single word transfer: address phase, then data phase
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk_reg(32'(hresp), 32'h0000_0000);
  endtask : xfer
  // Read a register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk_reg(rd, exp);
  endtask : rd_chk
  // Read the running count and compare
  task automatic cnt_chk;
    xfer(1'b0, ERRCNT_OFS, 32'h0000_0000);
    chk_cnt(rd, 32'(cnt_exp));
  endtask : cnt_chk
  // Whether a bit address is counted under the current location setup
  function automatic bit qual(input int a);
    if (c_user == 0 || c_loc == 0 || c_loc == 3) return 1'b1;
    if (c_loc == 2) return a == c_sb;
    return ((a - c_st + PL) % PL) < c_ln;
  endfunction : qual
  // Configure the block, reading back control and clamped range values
  task automatic cfg(input int m, mk, inc, loc, usr, s, l, sb);
    c_incr = inc;
    c_mode = m;
    c_mask = mk;
    c_loc = loc;
    c_user = usr;
    c_sb = sb;
    c_st = (s >= PL) ? PL - 1 : s;
    c_ln = (l == 0) ? 1 : ((l > PL - 1) ? PL - 1 : l);
    xfer(1'b1, CTRL_OFS, 32'(m | mk << 2 | inc << 3 | loc << 4 | usr << 6));
    xfer(1'b1, START_OFS, 32'(s));
    xfer(1'b1, LENGTH_OFS, 32'(l));
    xfer(1'b1, BITADDR_OFS, 32'(sb));
    rd_chk(CTRL_OFS, 32'(m | mk << 2 | inc << 3 | (loc == 3 ? 0 : loc) << 4 | usr << 6));
    rd_chk(START_OFS, 32'(c_st));
    rd_chk(LENGTH_OFS, 32'(c_ln));
  endtask : cfg
  // Random bits, optional sync losses; tracks running and captured counts
  task automatic burst(input int n, input bit lossy);
    bit e, l, q, s, r;
    for (int i = 0; i < n; i++) begin
      // A waiting capture gets a clean errored bit first
      e = armed || 1'($urandom_range(0, 1));
      s = !armed && ($urandom_range(0, 3) == 0);
      r = !armed && ($urandom_range(0, 3) == 0);
      l = lossy && (i % 3 == 0);
      q = e && qual(b_addr) && !(s && c_mode >= 2) && !(r && c_mask != 0);
      cnt_exp += int'(q) + (l ? c_incr : 0);
      if (armed && q) begin
        armed = 1'b0;
        hit_addr = b_addr;
        hit_left = PL;
        cap_exp = 0;
      end
      if (hit_left > 0) begin
        cap_exp += int'(q);
        hit_left--;
      end
      req <= 1'b1;
      err <= e;
      loss <= l;
      skp <= s;
      rsy <= r;
      b_addr = (b_addr + 1) % PL;
      @(posedge clk_in);
    end
    req <= 1'b0;
    loss <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : burst
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h9e8a_826d));
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd_chk(CTRL_OFS, 32'h0000_0008);
    rd_chk(CAPSTATE_OFS, 32'(CAPTURE_STATE_IDLE));
    rd_chk(CAPCNT_OFS, 32'h0000_0000);
    rd_chk(INCLIST_OFS, 32'h0000_0003);
    rd_chk(PATLEN_OFS, 32'(PL));
    rd_chk(8'h40, 32'h0000_0000);
    $display("reset values done");
    // Every mode and location setting, random range values
    for (int k = 0; k < 12; k++) begin
      cfg(k % 4, $urandom_range(0, 1), 1, (k + k / 4) % 4, int'(k != 11),
          $urandom_range(0, 12), $urandom_range(0, 12), $urandom_range(0, PL - 1));
      burst(16, 1'b0);
      cnt_chk();
    end
    // Corners: wrapping range, clamped start with zero length, single bit
    cfg(0, 0, 1, 1, 1, 6, 4, 0);
    burst(20, 1'b0);
    cnt_chk();
    cfg(0, 0, 1, 1, 1, 9, 0, 0);
    burst(20, 1'b0);
    cnt_chk();
    cfg(0, 0, 1, 2, 1, 0, 3, 3);
    burst(20, 1'b0);
    cnt_chk();
    $display("location filtering done");
    // Sync loss increments of zero and one, bit and symbol modes
    for (int k = 0; k < 4; k++) begin
      cfg(k % 2, 0, k / 2, 0, 0, 0, 1, 0);
      burst(12, 1'b1);
      cnt_chk();
    end
    $display("sync loss done");
    // Successful capture
    cfg(0, 0, 1, 0, 1, 0, 1, 0);
    xfer(1'b1, CAPCMD_OFS, 32'h0000_0001);
    armed = 1'b1;
    rd_chk(CAPCMD_OFS, 32'h0000_0001);
    rd_chk(CAPSTATE_OFS, 32'(CAPTURE_STATE_RUNNING));
    burst(24, 1'b0);
    rd_chk(CAPSTATE_OFS, 32'(CAPTURE_STATE_SUCCESS));
    rd_chk(CAPCMD_OFS, 32'h0000_0000);
    rd_chk(BITADDR_OFS, 32'(hit_addr));
    rd_chk(CAPCNT_OFS, 32'(cap_exp));
    cnt_chk();
    $display("capture success done");
    // Start in each mode, then stop: failed or aborted, results kept
    for (int m = 0; m < 4; m++) begin
      cfg(m, 0, 1, 0, 1, 0, 1, 5);
      xfer(1'b1, CAPCMD_OFS, 32'h0000_0001);
      rd_chk(CAPSTATE_OFS, 32'((m == 1 || m == 2) ? CAPTURE_STATE_FAILED : CAPTURE_STATE_RUNNING));
      // Last mode: stop while the hit is still being evaluated
      if (m == 3) begin
        cap_keep = cap_exp;
        armed = 1'b1;
        burst(3, 1'b0);
        cap_exp = cap_keep;
        hit_left = 0;
        rd_chk(CAPSTATE_OFS, 32'(CAPTURE_STATE_HIT));
      end
      xfer(1'b1, CAPCMD_OFS, 32'h0000_0002);
      rd_chk(CAPSTATE_OFS, 32'((m == 1 || m == 2) ? CAPTURE_STATE_FAILED : CAPTURE_STATE_ABORTED));
      rd_chk(CAPCMD_OFS, 32'h0000_0000);
      rd_chk(CAPCNT_OFS, 32'(cap_exp));
      if (m == 0 || m == 3) begin
        rd_chk(BITADDR_OFS, 32'h0000_0005);
      end
    end
    $display("capture abort and fail done");
    // Second reset in mid-run
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    b_addr = 0;
    cnt_exp = 0;
    c_user = 0;
    c_incr = 1;
    c_mode = 0;
    c_mask = 0;
    rd_chk(CAPSTATE_OFS, 32'(CAPTURE_STATE_IDLE));
    rd_chk(CTRL_OFS, 32'h0000_0008);
    rd_chk(CAPCNT_OFS, 32'h0000_0000);
    burst(10, 1'b0);
    cnt_chk();
    $display("second reset done");
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    $display("[ERR] %0t run timed out", $time);
    wrap_up();
  end
endmodule : error_location_counter_tb_top
`default_nettype wire

// ==== stream_source_model.sv ====
// Stream source model standing in for the comparator that feeds the block
`timescale 1ns/1ps
`default_nettype none
module stream_source_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bench commands, one compared bit per request
  input wire logic req_in,
  input wire logic err_in,
  input wire logic loss_in,
  input wire logic skip_in,
  input wire logic resync_in,
  // Comparator stream towards the block
  output var logic cmp_valid_out,
  output var logic bit_err_out,
  output var logic sym_err_out,
  output var logic skip_out,
  output var logic resync_out,
  output var logic sync_loss_out
);
  // ---------------------------------------------------------------
  // Stream register
  // ---------------------------------------------------------------
  // Between bits the error lines keep changing so no stale value helps
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmp_valid_out <= 1'b0;
      bit_err_out <= 1'b0;
      sym_err_out <= 1'b1;
      skip_out <= 1'b0;
      resync_out <= 1'b0;
      sync_loss_out <= 1'b0;
    end else if (req_in) begin
      cmp_valid_out <= 1'b1;
      bit_err_out <= err_in;
      sym_err_out <= err_in;
      skip_out <= skip_in;
      resync_out <= resync_in;
      sync_loss_out <= loss_in;
    end else begin
      cmp_valid_out <= 1'b0;
      bit_err_out <= ~bit_err_out;
      sym_err_out <= ~sym_err_out;
      skip_out <= ~skip_out;
      resync_out <= ~resync_out;
      sync_loss_out <= 1'b0;
    end
  end
endmodule : stream_source_model
`default_nettype wire
